/* File: verilog/field_store_predecrement.sv */
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Operation
// RQ1 - subtract field size from destination address, store field at the result
// RQ2 - destination register holds a bit address, used unscaled
// RQ3 - any field width from 1 to 32 bits is stored
// RQ4 - width and extension come from the last written field-size settings
// RQ5 - software keeps source and destination in the same register file
// RQ6 - source is the right-justified low bits of the source register
// RQ7 - decremented address is written back to the destination register
// RQ8 - select bit 0 picks first field size, 1 picks the second
// RQ9 - single 16-bit instruction word; status flags are left untouched
module field_store_predecrement (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register file read ports, combinational data
    output logic [4:0] rf_src_idx,
    output logic [4:0] rf_dst_idx,
    input wire logic [31:0] rf_src_data,
    input wire logic [31:0] rf_dst_data,
    // register file write port
    output logic rf_wr_en,
    output logic [4:0] rf_wr_idx,
    output logic [31:0] rf_wr_data,
    // memory field write path
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [31:0] mem_wr_addr,
    output logic [31:0] mem_wr_data,
    output logic [5:0] mem_wr_size,
    output logic mem_wr_ext
);
    // field size code 0 means a 32-bit field
    function automatic logic [5:0] field_width(input logic [4:0] code);
        field_width = (code == 5'h00) ? field_store_pkg::FULL_FIELD : {1'b0, code};
    endfunction

    function automatic logic [31:0] field_mask(input logic [5:0] width);
        logic [63:0] ones;
        ones = (64'h1 << width) - 64'h1;
        field_mask = ones[31:0];
    endfunction

    // bus address phase capture
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [15:0] instr_ff;
    logic [11:0] field_cfg_ff;
    logic illegal_ff;
    logic dropped_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] last_addr_ff;
    field_store_pkg::exec_state_t state_ff;
    field_store_pkg::exec_state_t nxt_state;

    wire addr_phase = hsel && htrans[1] && hready;
    wire [7:0] acc_addr = haddr[7:0];
    wire wr_instr = wr_pend_ff && (wr_addr_ff == field_store_pkg::INSTR_OFS);
    wire wr_cfg = wr_pend_ff && (wr_addr_ff == field_store_pkg::FIELD_CFG_OFS);
    wire wr_status = wr_pend_ff && (wr_addr_ff == field_store_pkg::STATUS_OFS);
    wire busy = (state_ff != field_store_pkg::ST_IDLE);

    // decode of a newly written instruction word
    wire [15:0] new_instr = hwdata[15:0];
    wire opcode_ok = (new_instr[15:field_store_pkg::OPCODE_LSB] ==
                      field_store_pkg::OPCODE_STORE_PREDEC); // RQ9
    wire issue = wr_instr && !busy && opcode_ok;
    wire reject = wr_instr && !busy && !opcode_ok;
    // a write while busy is refused rather than queued: no buffer is kept
    wire lost = wr_instr && busy;

    // operand fields of the held instruction
    wire fsel = instr_ff[field_store_pkg::FSEL_BIT];
    wire file_sel = instr_ff[field_store_pkg::FILE_BIT];
    wire [3:0] src_num = instr_ff[field_store_pkg::SRC_LSB +: 4];
    wire [3:0] dst_num = instr_ff[field_store_pkg::DST_LSB +: 4];

    // field size settings
    wire [4:0] fs_first = field_cfg_ff[field_store_pkg::FS_FIRST_LSB +: 5];
    wire [4:0] fs_second = field_cfg_ff[field_store_pkg::FS_SECOND_LSB +: 5];
    wire fe_first = field_cfg_ff[field_store_pkg::FE_FIRST_BIT];
    wire fe_second = field_cfg_ff[field_store_pkg::FE_SECOND_BIT];
    wire [5:0] cur_size = fsel ? field_width(fs_second) : field_width(fs_first); // RQ4 RQ8
    wire cur_ext = fsel ? fe_second : fe_first; // RQ8
    // address arithmetic wraps modulo 2^32, as the core's own adder does
    wire [31:0] predec_addr = rf_dst_data - {26'h0, cur_size}; // RQ1 RQ2
    wire [31:0] src_field = rf_src_data & field_mask(cur_size); // RQ6 RQ3
    wire store_done = (state_ff == field_store_pkg::ST_STORE) && mem_wr_ready;

    // both operands index one register file through the shared file bit
    assign rf_src_idx = {file_sel, src_num}; // RQ5
    assign rf_dst_idx = {file_sel, dst_num};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign mem_wr_valid = (state_ff == field_store_pkg::ST_STORE);

    always_comb begin
        case (state_ff)
            field_store_pkg::ST_IDLE: nxt_state = issue ? field_store_pkg::ST_FETCH
                                                        : field_store_pkg::ST_IDLE;
            field_store_pkg::ST_FETCH: nxt_state = field_store_pkg::ST_STORE;
            field_store_pkg::ST_STORE: nxt_state = mem_wr_ready ? field_store_pkg::ST_IDLE
                                                                : field_store_pkg::ST_STORE;
            default: nxt_state = field_store_pkg::ST_IDLE;
        endcase
    end

    wire [31:0] status_word = {29'h0, dropped_ff, illegal_ff, busy};
    wire [31:0] nxt_hrdata =
        (acc_addr == field_store_pkg::INSTR_OFS) ? {16'h0, instr_ff} :
        (acc_addr == field_store_pkg::FIELD_CFG_OFS) ? {20'h0, field_cfg_ff} :
        (acc_addr == field_store_pkg::STATUS_OFS) ? status_word :
        (acc_addr == field_store_pkg::LAST_ADDR_OFS) ? last_addr_ff : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff <= 32'h0;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            wr_addr_ff <= acc_addr;
            if (addr_phase && !hwrite) begin
                hrdata_ff <= nxt_hrdata;
            end
        end
    end

    // a setting written after the fetch cycle first applies to the next store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            field_cfg_ff <= field_store_pkg::FIELD_CFG_RESET;
            instr_ff <= field_store_pkg::INSTR_RESET;
        end else begin
            if (wr_cfg) begin
                field_cfg_ff <= hwdata[11:0]; // RQ4
            end
            if (issue) begin
                instr_ff <= new_instr; // RQ9
            end
        end
    end

    // sticky errors; a hardware set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            illegal_ff <= 1'b0;
            dropped_ff <= 1'b0;
        end else begin
            illegal_ff <= reject || (illegal_ff &&
                          !(wr_status && hwdata[field_store_pkg::STAT_ILLEGAL_BIT]));
            dropped_ff <= lost || (dropped_ff &&
                          !(wr_status && hwdata[field_store_pkg::STAT_DROPPED_BIT]));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= field_store_pkg::ST_IDLE;
            mem_wr_addr <= 32'h0;
            mem_wr_data <= 32'h0;
            mem_wr_size <= 6'h00;
            mem_wr_ext <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == field_store_pkg::ST_FETCH) begin
                mem_wr_addr <= predec_addr; // RQ1 RQ2
                mem_wr_data <= src_field; // RQ6
                mem_wr_size <= cur_size; // RQ3
                mem_wr_ext <= cur_ext;
            end
        end
    end

    // destination gets the same decremented address the memory saw
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_wr_en <= 1'b0;
            rf_wr_idx <= 5'h00;
            rf_wr_data <= 32'h0;
            last_addr_ff <= 32'h0;
        end else begin
            rf_wr_en <= store_done; // RQ7
            if (store_done) begin
                rf_wr_idx <= rf_dst_idx;
                rf_wr_data <= mem_wr_addr; // RQ7
                last_addr_ff <= mem_wr_addr;
            end
        end
    end

    a_predec_addr: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
        (state_ff == field_store_pkg::ST_FETCH) |=>
        mem_wr_valid && (mem_wr_addr == $past(rf_dst_data) - {26'h0, $past(cur_size)}))
        else $error("store address is not destination minus field size");

    a_bit_granular: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
        (state_ff == field_store_pkg::ST_FETCH) |=>
        (mem_wr_addr[3:0] == $past(rf_dst_data[3:0]) - $past(cur_size[3:0])))
        else $error("bit address low bits were scaled or lost");

    a_width_range: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        mem_wr_valid |-> (mem_wr_size >= 6'h01) && (mem_wr_size <= 6'h20)
        && ((mem_wr_data & ~field_mask(mem_wr_size)) == 32'h0))
        else $error("field width outside 1 to 32 or data wider than field");

    a_size_source: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
        (state_ff == field_store_pkg::ST_FETCH) && fsel |=>
        (mem_wr_size == field_width($past(fs_second))) && (mem_wr_ext == $past(fe_second)))
        else $error("second field setting not used");

    a_src_justify: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
        (state_ff == field_store_pkg::ST_FETCH) |=>
        (mem_wr_data == ($past(rf_src_data) & field_mask(mem_wr_size))))
        else $error("source field not right justified");

    a_addr_wback: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        mem_wr_valid && mem_wr_ready |=>
        rf_wr_en && (rf_wr_data == $past(mem_wr_addr)) && (rf_wr_idx == $past(rf_dst_idx)))
        else $error("decremented address not written back");

    a_select_first: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
        (state_ff == field_store_pkg::ST_FETCH) && !fsel |=>
        (mem_wr_size == field_width($past(fs_first))) && (mem_wr_ext == $past(fe_first)))
        else $error("select bit 0 did not pick the first field size");

    a_single_word: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        reject |=> (state_ff == field_store_pkg::ST_IDLE) && illegal_ff && !rf_wr_en)
        else $error("foreign opcode started an execution");

    // the far side may hold off for any time; the request must not drift meanwhile
    a_store_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
        mem_wr_valid && !mem_wr_ready |=>
        mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data)
        && $stable(mem_wr_size) && $stable(mem_wr_ext))
        else $error("store request changed before it was accepted");

    // an accepted word spends one cycle reading operands before it stores
    a_issue_order: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        issue |=> (state_ff == field_store_pkg::ST_FETCH) && (instr_ff == $past(new_instr))
        ##1 mem_wr_valid)
        else $error("accepted instruction did not reach the store step");

    a_drop_busy: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        lost |=> dropped_ff && (instr_ff == $past(instr_ff)))
        else $error("instruction written while busy was not dropped");

    a_foreign_kept: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        reject |=> (instr_ff == $past(instr_ff)))
        else $error("foreign opcode replaced the held instruction");

    // the register file sees exactly one write per accepted store
    a_wback_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        rf_wr_en |=> !rf_wr_en)
        else $error("address write-back lasted more than one cycle");

    a_wback_match: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        rf_wr_en |-> (last_addr_ff == rf_wr_data) && (rf_wr_idx == rf_dst_idx)
        && (rf_wr_data == mem_wr_addr))
        else $error("write-back and reported address disagree");

    a_idle_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        !mem_wr_valid |=> !rf_wr_en)
        else $error("write-back without an accepted store");

    // sticky status and settings
    a_cfg_take: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
        wr_cfg |=> (field_cfg_ff == $past(hwdata[11:0])))
        else $error("field setting write not taken");

    a_clear_illegal: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        wr_status && hwdata[field_store_pkg::STAT_ILLEGAL_BIT] && !reject |=> !illegal_ff)
        else $error("illegal flag not cleared by software");

    a_clear_dropped: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        wr_status && hwdata[field_store_pkg::STAT_DROPPED_BIT] && !lost |=> !dropped_ff)
        else $error("dropped flag not cleared by software");

    // flags only fall through a software clear
    a_illegal_keep: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        illegal_ff && !wr_status |=> illegal_ff)
        else $error("illegal flag fell without a clear");

    a_dropped_keep: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
        dropped_ff && !wr_status |=> dropped_ff)
        else $error("dropped flag fell without a clear");

    // code 0 stands for a full 32-bit field, never for width 0
    a_size_legal: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        (state_ff == field_store_pkg::ST_FETCH) |->
        (cur_size != 6'h00) && (cur_size <= field_store_pkg::FULL_FIELD))
        else $error("selected field width outside 1 to 32");
endmodule

/* File: verilog/field_store_pkg.sv */
package field_store_pkg;
    // register offsets on the AHB-Lite slave (byte addresses)
    localparam logic [7:0] INSTR_OFS = 8'h00;
    localparam logic [7:0] FIELD_CFG_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] LAST_ADDR_OFS = 8'h0C;

    // opcode pattern in bits 15:10 of the instruction word
    localparam logic [5:0] OPCODE_STORE_PREDEC = 6'h28;
    localparam int OPCODE_LSB = 10;
    localparam int FSEL_BIT = 9;
    localparam int SRC_LSB = 5;
    localparam int FILE_BIT = 4;
    localparam int DST_LSB = 0;

    // field configuration register layout
    localparam int FS_FIRST_LSB = 0;
    localparam int FE_FIRST_BIT = 5;
    localparam int FS_SECOND_LSB = 6;
    localparam int FE_SECOND_BIT = 11;
    localparam logic [11:0] FIELD_CFG_RESET = 12'h000;

    // status register layout
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ILLEGAL_BIT = 1;
    localparam int STAT_DROPPED_BIT = 2;

    localparam logic [5:0] FULL_FIELD = 6'h20;
    localparam logic [15:0] INSTR_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_STORE = 2'b11
    } exec_state_t;
endpackage

/* File: tb/test_field_store_predecrement.sv */
`timescale 1ns/1ps
module test_field_store_predecrement;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rf_wr_data, mem_wr_addr, mem_wr_data;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] rf_src_idx, rf_dst_idx, rf_wr_idx;
    logic rf_wr_en, mem_wr_valid, mem_wr_ready, mem_wr_ext, cap_ext;
    logic [5:0] mem_wr_size, cap_size;
    logic [31:0] rf [32];
    logic [31:0] cap_addr, cap_data, rd;
    int n_acc = 0;
    int mismatches = 0;
    int num_checks = 0;
    // single slave, so its own ready closes the loop
    wire hready = hreadyout;
    wire [31:0] rf_src_data = rf[rf_src_idx];
    wire [31:0] rf_dst_data = rf[rf_dst_idx];

    field_store_predecrement i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rf_src_idx(rf_src_idx),
        .rf_dst_idx(rf_dst_idx), .rf_src_data(rf_src_data), .rf_dst_data(rf_dst_data),
        .rf_wr_en(rf_wr_en), .rf_wr_idx(rf_wr_idx), .rf_wr_data(rf_wr_data),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .mem_wr_size(mem_wr_size), .mem_wr_ext(mem_wr_ext));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (mem_wr_valid && mem_wr_ready) begin
            cap_addr <= mem_wr_addr;
            cap_data <= mem_wr_data;
            cap_size <= mem_wr_size;
            cap_ext <= mem_wr_ext;
            n_acc <= n_acc + 1;
        end
        if (rf_wr_en) begin
            rf[rf_wr_idx] <= rf_wr_data;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one whole-word transfer; read data is taken at the closing edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_acc(input int n);
        for (int i = 0; i < 200 && n_acc < n; i++) @(posedge hclk);
        repeat (3) @(posedge hclk);
    endtask

    task automatic store(input int i, input logic [31:0] src, input logic [31:0] dst,
                         input logic [5:0] sz);
        logic f, fl, ext;
        logic [3:0] s, d;
        logic [11:0] cfg;
        logic [31:0] ea, ed, ins;
        int n;
        f = i[0];
        fl = i[1];
        ext = i[2];
        s = 4'(i);
        d = 4'(i + 5);
        ea = dst - {26'h0, sz};
        ed = (sz == 6'h20) ? src : src & ((32'h1 << sz) - 32'h1);
        // the unselected slot holds size 3 so a wrong select shows up
        cfg = f ? {ext, sz[4:0], ~ext, 5'd3} : {~ext, 5'd3, ext, sz[4:0]};
        // upper half is noise: only the low 16 bits form the instruction
        ins = {16'hC3A5, package_free_op(f, s, fl, d)};
        rf[{fl, s}] <= src;
        rf[{fl, d}] <= dst;
        n = n_acc;
        bus(field_store_pkg::FIELD_CFG_OFS, 1'b1, {20'h0, cfg});
        bus(field_store_pkg::INSTR_OFS, 1'b1, ins);
        wait_acc(n + 1);
        check("mem_addr", cap_addr, ea);
        check("mem_data", cap_data, ed);
        check("mem_size", {26'h0, cap_size}, {26'h0, sz});
        check("mem_ext", {31'h0, cap_ext}, {31'h0, ext});
        check("dst_reg", rf[{fl, d}], ea);
        bus(field_store_pkg::LAST_ADDR_OFS, 1'b0, 32'h0);
        check("last_addr", rd, ea);
        bus(field_store_pkg::INSTR_OFS, 1'b0, 32'h0);
        check("instr_word", rd, {16'h0, ins[15:0]});
    endtask

    function automatic logic [15:0] package_free_op(input logic f, input logic [3:0] s,
                                                     input logic fl, input logic [3:0] d);
        return {field_store_pkg::OPCODE_STORE_PREDEC, f, s, fl, d};
    endfunction

    localparam logic [5:0] SZ [10] = '{6'd1, 6'd8, 6'd13, 6'd16, 6'd19, 6'd24, 6'd27, 6'd31,
                                      6'd32, 6'd8};
    localparam logic [31:0] DST [10] = '{32'h00015530, 32'h0001552D, 32'h00015528, 32'h00015528,
        32'h00015523, 32'h00015520, 32'h00015524, 32'h0001554D, 32'h00015540, 32'h00000004};

    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        end_of_test();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        mem_wr_ready = 1'b1;
        for (int k = 0; k < 32; k++) rf[k] = 32'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(field_store_pkg::FIELD_CFG_OFS, 1'b0, 32'h0);
        check("cfg_reset", rd, 32'h0);
        bus(field_store_pkg::STATUS_OFS, 1'b0, 32'h0);
        check("status_reset", rd, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        check("hreadyout", {31'h0, hreadyout}, 32'h1);
        bus(8'h10, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 10; i++) store(i, i[0] ? 32'hA5C396F1 : 32'hFFFFFFFF, DST[i], SZ[i]);
        $display("width table test done");
        mem_wr_ready <= 1'b0;
        store_stalled();
        $display("stall test done");
        bus(field_store_pkg::INSTR_OFS, 1'b1, {16'h0, 6'h29, 10'h0});
        bus(field_store_pkg::STATUS_OFS, 1'b0, 32'h0);
        check("illegal", rd, 32'h2);
        bus(field_store_pkg::STATUS_OFS, 1'b1, 32'h2);
        bus(field_store_pkg::STATUS_OFS, 1'b0, 32'h0);
        check("illegal_clr", rd, 32'h0);
        $display("illegal test done");
        end_of_test();
    end

    // far side holds off acceptance; a second issue meanwhile must be dropped
    task automatic store_stalled;
        int n;
        n = n_acc;
        rf[3] <= 32'h00001000;
        rf[4] <= 32'h12345678;
        bus(field_store_pkg::FIELD_CFG_OFS, 1'b1, 32'h00000010);
        bus(field_store_pkg::INSTR_OFS, 1'b1, {16'h0, package_free_op(1'b0, 4'd4, 1'b0, 4'd3)});
        bus(field_store_pkg::INSTR_OFS, 1'b1, {16'h0, package_free_op(1'b0, 4'd4, 1'b0, 4'd3)});
        bus(field_store_pkg::STATUS_OFS, 1'b0, 32'h0);
        check("busy_drop", rd, 32'h5);
        check("stall_valid", {31'h0, mem_wr_valid}, 32'h1);
        check("stall_addr", mem_wr_addr, 32'h00000FF0);
        mem_wr_ready <= 1'b1;
        wait_acc(n + 1);
        check("one_store", 32'(n_acc - n), 32'h1);
        check("stall_data", cap_data, 32'h00005678);
        check("stall_dst", rf[3], 32'h00000FF0);
        bus(field_store_pkg::STATUS_OFS, 1'b1, 32'h4);
        bus(field_store_pkg::STATUS_OFS, 1'b0, 32'h0);
        check("drop_clr", rd, 32'h0);
    endtask
endmodule
